// >>> hw/epa_pkg.sv
/*
  package for the program-memory access and checksum registers:
  link register addresses, status bit positions, reset values, crc constants
  and the carrier structs shared by the register block and its link front end.
  assumes an 8-bit register select and 8-bit data on the debug link.
*/
package epa_pkg;

  // link register addresses
  localparam logic [7:0] EPA_ADDR_HALT_CONTROL = 8'h02;
  localparam logic [7:0] EPA_ADDR_CRC_BYTE0 = 8'hA9;
  localparam logic [7:0] EPA_ADDR_CRC_BYTE1 = 8'hAA;
  localparam logic [7:0] EPA_ADDR_CRC_BYTE2 = 8'hAB;
  localparam logic [7:0] EPA_ADDR_CRC_BYTE3 = 8'hAC;
  localparam logic [7:0] EPA_ADDR_MEM_ADDR_LOW = 8'hAE;
  localparam logic [7:0] EPA_ADDR_MEM_ADDR_HIGH = 8'hAF;
  localparam logic [7:0] EPA_ADDR_STATUS = 8'hB7;
  localparam logic [7:0] EPA_ADDR_DATA_BYTE = 8'hBF;
  localparam logic [7:0] EPA_ADDR_PROG_CONTROL = 8'hDF;

  // status field positions
  localparam int EPA_STAT_WRLK_BIT = 7;
  localparam int EPA_STAT_RDLK_BIT = 6;
  localparam int EPA_STAT_ERR_BIT = 0;
  // link status byte: busy bit
  localparam int EPA_LINK_BUSY_BIT = 7;

  // reset values
  localparam logic [7:0] EPA_RESET_BYTE = 8'h00;
  localparam logic [15:0] EPA_RESET_ADDR = 16'h0000;

  // crc setup
  localparam logic [7:0] EPA_BLOCK_LOW_BYTE = 8'h00;
  localparam logic [15:0] EPA_FULL_START = 16'h0000;
  localparam logic [15:0] EPA_MEM_LAST = 16'hFFFF;
  localparam logic [15:0] EPA_CRC16_POLY = 16'h1021;
  localparam logic [15:0] EPA_CRC16_INIT = 16'hFFFF;
  localparam logic [31:0] EPA_CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] EPA_CRC32_INIT = 32'hFFFFFFFF;

  // one register access request from the link side
  typedef struct packed {
    logic wr;        // write when set, read otherwise
    logic [7:0] sel; // selected register
    logic [7:0] data;// write data
  } epa_req_type;

  // memory port request toward the program memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } epa_mem_type;

  typedef enum logic [2:0] {
    EPA_IDLE = 3'b000,
    EPA_MREAD = 3'b001,
    EPA_MWRITE = 3'b010,
    EPA_CRC16 = 3'b011,
    EPA_CRC32 = 3'b100
  } epa_state_type;

endpackage

// >>> hw/epa_link_port.sv
/*
  link-clock front end: captures a register access from the debug link on
  the link clock and hands it to the core clock with a toggle handshake;
  the answer toggle comes back through a two-flop synchroniser, then the read byte is taken.
  assumes the link holds its request until link_ack_out toggles back.
*/
`timescale 1ns/1ps
module epa_link_port
  import epa_pkg::*;
(
  input wire logic link_clk_in,           // link clock
  input wire logic link_rst_b_in,         // link-side reset, active low
  input wire logic link_strobe_in,        // one-cycle access strobe
  input wire epa_req_type link_req_in,    // access contents
  output logic link_ack_out,              // toggles when answer ready
  output logic [7:0] link_rdata_out,      // read answer
  input wire logic core_clk_in,           // core clock
  input wire logic rst_b_in,              // core reset, active low
  output logic core_valid_out,            // one-cycle request pulse on core clock
  output epa_req_type core_req_out,       // request held stable across handshake
  input wire logic core_done_in,          // core finished, answer valid
  input wire logic [7:0] core_rdata_in    // core answer byte
);

  typedef struct packed {
    logic req_tgl;
    epa_req_type req;
    logic [1:0] ack_sync;
    logic ack_seen;
    logic ack_out;
    logic [7:0] rdata;
  } epa_lstate_type;

  typedef struct packed {
    logic [1:0] req_sync;
    logic req_seen;
    logic valid;
    logic ack_tgl;
    logic [7:0] rdata;
  } epa_cstate_type;

  epa_lstate_type l, next_l;
  epa_cstate_type c, next_c;

  // link side: launch a request toggle, wait for the returned toggle
  always_comb
  begin
    next_l = l;
    next_l.ack_sync = {l.ack_sync[0], c.ack_tgl};
    if (link_strobe_in)
    begin
      next_l.req = link_req_in;
      next_l.req_tgl = ~l.req_tgl;
    end
    if (l.ack_sync[1] != l.ack_seen)
    begin
      // answer word was stable before the toggle, safe to take
      next_l.ack_seen = l.ack_sync[1];
      next_l.rdata = c.rdata;
      next_l.ack_out = ~l.ack_out;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_b_in)
      l <= '0;
    else
      l <= next_l;
  end

  // core side: detect the request toggle after two flops
  always_comb
  begin
    next_c = c;
    next_c.valid = 1'b0;
    next_c.req_sync = {c.req_sync[0], l.req_tgl};
    if (c.req_sync[1] != c.req_seen)
    begin
      next_c.req_seen = c.req_sync[1];
      next_c.valid = 1'b1;
    end
    if (core_done_in)
    begin
      next_c.rdata = core_rdata_in;
      next_c.ack_tgl = ~c.ack_tgl;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
      c <= '0;
    else
      c <= next_c;
  end

  assign link_ack_out = l.ack_out;
  assign link_rdata_out = l.rdata;
  assign core_valid_out = c.valid;
  // request word was frozen before the toggle left the link side
  assign core_req_out = l.req;

endmodule

// >>> hw/epa_regs.sv
/*
  program-memory access registers reached over the two-wire debug link:
  programming control, data byte, status, 16-bit address and four crc bytes.
  crc runs over program memory read one byte every three cycles through mem_*.
  assumes the core is halted while the tool works; memory answers a read
  in the cycle after mem_out.rd with mem_rdata_in, and a write is accepted
  in one cycle. lock inputs come from the security logic on the core clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// [R1] programming control at 0xDF gates memory writes
// [R2] data byte at 0xBF carries memory data
// [R3] address high 0xAF, low 0xAE form 16 bits
// [R4] crc byte0 write starts 256-byte crc16
// [R5] written byte is start high, low 0x00
// [R6] crc16 result msb byte1, lsb byte0
// [R7] crc byte1 write starts full crc32
// [R8] full crc always starts at 0x0000
// [R9] crc32 result stored byte3 down byte0
// [R10] status: write lock, read lock, error
// [R11] link status bit 7 while busy
// [R12] halt control at 0x02 halts device
module epa_regs
  import epa_pkg::*;
(
  input wire logic core_clk_in,           // core clock, 100 MHz
  input wire logic rst_b_in,              // synchronous reset, active low
  input wire logic link_clk_in,           // debug link clock
  input wire logic link_rst_b_in,         // link-side reset, active low
  input wire logic link_strobe_in,        // one link-cycle access strobe
  input wire epa_req_type link_req_in,    // register select, direction, data
  output logic link_ack_out,              // toggles when access finished
  output logic [7:0] link_rdata_out,      // data read answer
  output logic [7:0] link_status_out,     // link status byte, bit 7 busy
  output epa_mem_type mem_out,            // program memory request
  input wire logic [7:0] mem_rdata_in,    // program memory read data
  input wire logic wr_lock_in,            // current address is write-locked
  input wire logic rd_lock_in,            // current address is read-locked
  output logic halt_out                   // core halt request
);

  // whole state of the core side
  typedef struct packed {
    epa_state_type st;
    logic [7:0] prog_ctl;
    logic [7:0] data_byte;
    logic [15:0] addr;
    logic [31:0] crc;
    logic err;
    logic [7:0] halt_ctl;
    logic [15:0] ptr;
    logic rd_wait;
    logic done;
    logic [7:0] rdata;
    epa_mem_type mem;
    logic busy; // registered busy level for the link side
    logic halt; // registered halt request
  } epa_core_type;

  epa_core_type r, next_r;

  logic req_valid;
  epa_req_type req;

  epa_link_port u_link
  (
    .link_clk_in(link_clk_in),
    .link_rst_b_in(link_rst_b_in),
    .link_strobe_in(link_strobe_in),
    .link_req_in(link_req_in),
    .link_ack_out(link_ack_out),
    .link_rdata_out(link_rdata_out),
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .core_valid_out(req_valid),
    .core_req_out(req),
    .core_done_in(r.done),
    .core_rdata_in(r.rdata)
  );

  // busy level to the link clock through two flops
  logic [1:0] busy_link;
  logic [7:0] link_status;

  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_b_in)
      busy_link <= 2'b00;
    else
      busy_link <= {busy_link[0], r.busy};
  end

  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_b_in)
      link_status <= EPA_RESET_BYTE;
    else
    begin
      link_status <= EPA_RESET_BYTE;
      // [R11] busy bit shown
      link_status[EPA_LINK_BUSY_BIT] <= busy_link[1];
    end
  end

  // bitwise crc16 update of one byte, msb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[15] ^ d[i])
        v = {v[14:0], 1'b0} ^ EPA_CRC16_POLY;
      else
        v = {v[14:0], 1'b0};
    end
    return v;
  endfunction

  // bitwise crc32 update of one byte, msb first
  function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] v;
    v = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[31] ^ d[i])
        v = {v[30:0], 1'b0} ^ EPA_CRC32_POLY;
      else
        v = {v[30:0], 1'b0};
    end
    return v;
  endfunction

  // register reads, decode of link selects
  function automatic logic [7:0] read_mux(input epa_core_type s, input logic [7:0] sel,
                                          input logic wl, input logic rl);
    logic [7:0] v;
    v = EPA_RESET_BYTE;
    case (sel)
      EPA_ADDR_HALT_CONTROL: v = s.halt_ctl;
      EPA_ADDR_PROG_CONTROL: v = s.prog_ctl;
      EPA_ADDR_DATA_BYTE: v = s.data_byte;
      EPA_ADDR_MEM_ADDR_LOW: v = s.addr[7:0];
      EPA_ADDR_MEM_ADDR_HIGH: v = s.addr[15:8];
      EPA_ADDR_CRC_BYTE0: v = s.crc[7:0];
      EPA_ADDR_CRC_BYTE1: v = s.crc[15:8];
      EPA_ADDR_CRC_BYTE2: v = s.crc[23:16];
      EPA_ADDR_CRC_BYTE3: v = s.crc[31:24];
      EPA_ADDR_STATUS:
      begin
        // [R10] lock and error flags
        v[EPA_STAT_WRLK_BIT] = wl;
        v[EPA_STAT_RDLK_BIT] = rl;
        v[EPA_STAT_ERR_BIT] = s.err;
      end
      default: v = EPA_RESET_BYTE; // unmapped selects read zero
    endcase
    return v;
  endfunction

  // core state update
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.mem.rd = 1'b0;
    next_r.mem.wr = 1'b0;
    case (r.st)
      EPA_IDLE:
      begin
        if (req_valid && !req.wr)
        begin
          next_r.rdata = read_mux(r, req.sel, wr_lock_in, rd_lock_in);
          next_r.done = 1'b1;
        end
        else if (req_valid)
        begin
          next_r.done = 1'b1;
          case (req.sel)
            // [R12] halt control register
            EPA_ADDR_HALT_CONTROL: next_r.halt_ctl = req.data;
            // [R1] programming enable store
            EPA_ADDR_PROG_CONTROL: next_r.prog_ctl = req.data;
            // [R3] address low byte
            EPA_ADDR_MEM_ADDR_LOW: next_r.addr[7:0] = req.data;
            // [R3] address high byte
            EPA_ADDR_MEM_ADDR_HIGH: next_r.addr[15:8] = req.data;
            EPA_ADDR_CRC_BYTE2: next_r.crc[23:16] = req.data;
            EPA_ADDR_CRC_BYTE3: next_r.crc[31:24] = req.data;
            EPA_ADDR_DATA_BYTE:
            begin
              next_r.data_byte = req.data;
              next_r.done = 1'b0;
              // [R1] write only when enabled
              if (r.prog_ctl != EPA_RESET_BYTE && !wr_lock_in && r.halt_ctl != EPA_RESET_BYTE)
              begin
                // [R2] data byte to memory
                next_r.mem.wr = 1'b1;
                next_r.mem.addr = r.addr;
                next_r.mem.wdata = req.data;
                next_r.err = 1'b0;
                next_r.st = EPA_MWRITE;
              end
              else
              begin
                // refused write flags a security error
                next_r.err = 1'b1;
                next_r.done = 1'b1;
              end
            end
            EPA_ADDR_CRC_BYTE0:
            begin
              // [R4] start block crc16
              // [R5] low start byte forced
              next_r.ptr = {req.data, EPA_BLOCK_LOW_BYTE};
              next_r.crc = {16'h0000, EPA_CRC16_INIT};
              next_r.st = EPA_CRC16;
              next_r.rd_wait = 1'b0;
              next_r.done = 1'b0; // answer only when the run ends
            end
            EPA_ADDR_CRC_BYTE1:
            begin
              // [R7] start full crc32
              // [R8] always from zero
              next_r.ptr = EPA_FULL_START;
              next_r.crc = EPA_CRC32_INIT;
              next_r.st = EPA_CRC32;
              next_r.rd_wait = 1'b0;
              next_r.done = 1'b0; // answer only when the run ends
            end
            default: next_r.done = 1'b1; // ignored write
          endcase
        end
      end
      EPA_MWRITE:
      begin
        // memory takes the byte in one cycle
        next_r.st = EPA_IDLE;
        next_r.done = 1'b1;
      end
      EPA_CRC16, EPA_CRC32:
      begin
        // issue one read, wait while it is on the bus, fold the answer next
        if (r.mem.rd)
        begin
          // memory samples the request now and answers one cycle later
          next_r.rd_wait = 1'b1;
        end
        else if (!r.rd_wait)
        begin
          next_r.mem.rd = 1'b1;
          next_r.mem.addr = r.ptr;
          next_r.rd_wait = 1'b1;
        end
        else
        begin
          next_r.rd_wait = 1'b0;
          next_r.ptr = r.ptr + 16'h0001;
          if (r.st == EPA_CRC16)
          begin
            // [R6] result msb byte1, lsb byte0
            next_r.crc[15:0] = crc16_byte(r.crc[15:0], mem_rdata_in);
            if (r.ptr[7:0] == 8'hFF)
            begin
              next_r.st = EPA_IDLE;
              next_r.done = 1'b1;
            end
          end
          else
          begin
            // [R9] result byte3 down byte0
            next_r.crc = crc32_byte(r.crc, mem_rdata_in);
            if (r.ptr == EPA_MEM_LAST)
            begin
              next_r.st = EPA_IDLE;
              next_r.done = 1'b1;
            end
          end
        end
      end
      default: next_r.st = EPA_IDLE;
    endcase
    // busy and halt leave as flop outputs so no decode glitch crosses over
    next_r.busy = (next_r.st != EPA_IDLE);
    // [R12] halt while control nonzero
    next_r.halt = (next_r.halt_ctl != EPA_RESET_BYTE);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      r <= '0;
      r.st <= EPA_IDLE;
    end
    else
      r <= next_r;
  end

  assign mem_out = r.mem;
  // [R12] halt pin from its own flop
  assign halt_out = r.halt;
  assign link_status_out = link_status;

endmodule

// >>> test/epa_regs_props.sv
/*
  checker on epa_regs ports: memory pulses, crc runs and the link ack.
  assumes it is bound to epa_regs from the bench top.
*/
`timescale 1ns/1ps
module epa_regs_props
  import epa_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic rst_b_in, // core reset
  input wire logic link_clk_in, // link clock
  input wire logic link_rst_b_in, // link reset
  input wire logic link_strobe_in, // access strobe
  input wire logic link_ack_out, // access done toggle
  input wire logic [7:0] link_status_out, // bit 7 busy
  input wire epa_mem_type mem_out, // memory request
  input wire logic halt_out // halt request
);
  logic [16:0] run_cnt; // reads in the current crc run
  logic pend; // link access outstanding

  // a read with none three cycles back opens a new run
  always_ff @(posedge core_clk_in)
    if (!rst_b_in)
      run_cnt <= '0;
    else if (mem_out.rd)
      run_cnt <= $past(mem_out.rd, 3) ? run_cnt + 17'h1 : 17'h1;

  // a strobe opens an access, the ack toggle closes it
  always_ff @(posedge link_clk_in)
    if (!link_rst_b_in)
      pend <= 1'b0;
    else if (link_strobe_in)
      pend <= 1'b1;
    else if (link_ack_out != $past(link_ack_out))
      pend <= 1'b0;

  sequence s_first_rd;
    mem_out.rd && !$past(mem_out.rd, 3);
  endsequence
  sequence s_run;
    mem_out.rd ##3 mem_out.rd ##3 mem_out.rd ##3 mem_out.rd;
  endsequence

  a_rd_wr_excl: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // one memory op
    !(mem_out.rd && mem_out.wr)) else $error("memory read and write together");
  a_rd_spacing: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // read wait fold
    mem_out.rd |=> !mem_out.rd ##1 !mem_out.rd) else $error("memory reads too close");
  a_crc_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // address steps
    mem_out.rd ##3 mem_out.rd |-> mem_out.addr == $past(mem_out.addr, 3) + 16'h1)
    else $error("crc address did not step by one");
  a_block_start: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // low byte zero
    s_first_rd |-> mem_out.addr[7:0] == EPA_BLOCK_LOW_BYTE) else $error("crc run start not aligned");
  a_block_len: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // run length
    mem_out.rd ##3 !mem_out.rd |-> run_cnt == 17'h100 || run_cnt == 17'h10000)
    else $error("crc run length wrong");
  a_busy_shown: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // busy while crc
    s_run |-> link_status_out[EPA_LINK_BUSY_BIT]) else $error("busy low during crc");
  a_wr_halted: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // write needs halt
    mem_out.wr |-> halt_out) else $error("memory write while not halted");
  a_ack_cause: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in) // ack answers strobe
    $changed(link_ack_out) |-> pend) else $error("ack toggled with no access");
endmodule

// >>> test/epa_mem_model.sv
/*
  program memory stand-in: answers a read one cycle after the pulse with
  address high xor low, and logs reads and writes since the last clear.
  assumes the core clock and epa_mem_type request pulses.
*/
`timescale 1ns/1ps
module epa_mem_model
  import epa_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic clear_in, // restart the logs
  input wire epa_mem_type mem_in, // request from the block
  output logic [7:0] rdata_out, // read answer
  output logic [16:0] rd_cnt_out, // reads since clear
  output logic [15:0] first_out, // first read address
  output logic [7:0] wr_cnt_out, // writes since clear
  output logic [23:0] wr_out // last write address, data
);
  // between reads the bus flips, so a late sample never sees a kept value
  always_ff @(posedge clk_in)
  begin
    rdata_out <= mem_in.rd ? (mem_in.addr[15:8] ^ mem_in.addr[7:0]) : ~rdata_out;
    if (clear_in)
    begin
      rd_cnt_out <= '0;
      wr_cnt_out <= '0;
    end
    else
    begin
      if (mem_in.rd && rd_cnt_out == '0)
        first_out <= mem_in.addr;
      if (mem_in.rd)
        rd_cnt_out <= rd_cnt_out + 17'h1;
      if (mem_in.wr)
      begin
        wr_cnt_out <= wr_cnt_out + 8'h1;
        wr_out <= {mem_in.addr, mem_in.wdata};
      end
    end
  end
endmodule

// >>> test/tb.sv
/*
  bench for epa_regs: link accesses, refused and accepted memory writes,
  a block crc and an aborted full crc.
  assumes epa_mem_model as program memory and the bound epa_regs_props.
*/
`timescale 1ns/1ps
module tb
  import epa_pkg::*;
;
  logic core_clk_in = 1'b0; // 10 ns
  logic link_clk_in = 1'b1; // 12 ns, rising edges never meet the core's
  logic rst_b_in = 1'b0; // core reset
  logic link_rst_b_in = 1'b0; // link reset
  logic link_strobe_in = 1'b0; // access strobe
  epa_req_type link_req_in = '0; // access contents
  logic wr_lock_in = 1'b0; // write lock level
  logic rd_lock_in = 1'b0; // read lock level
  logic clr = 1'b0; // clears memory logs
  logic link_ack_out;
  logic [7:0] link_rdata_out;
  logic [7:0] link_status_out;
  epa_mem_type mem_out;
  logic [7:0] mem_rdata_in;
  logic halt_out;
  logic [16:0] rd_cnt;
  logic [15:0] first;
  logic [7:0] wr_cnt;
  logic [23:0] wr;
  logic ack0; // ack level before a strobe
  logic ack_seen; // ack level at the last link edge
  logic [15:0] me; // popped note
  logic [15:0] q [$]; // notes: mask, value
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [7:0] regs [9] = '{8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAE, 8'hAF, 8'hBF, 8'hDF, 8'h02};
  localparam logic [7:0] rw [5] = '{8'hAE, 8'hAF, 8'hBF, 8'hDF, 8'h02};
  // prog, halt, lock; only the last may write
  localparam logic [2:0] cs [4] = '{3'h2, 3'h4, 3'h7, 3'h6};

  epa_regs dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
    .link_rst_b_in(link_rst_b_in), .link_strobe_in(link_strobe_in), .link_req_in(link_req_in),
    .link_ack_out(link_ack_out), .link_rdata_out(link_rdata_out), .link_status_out(link_status_out),
    .mem_out(mem_out), .mem_rdata_in(mem_rdata_in), .wr_lock_in(wr_lock_in),
    .rd_lock_in(rd_lock_in), .halt_out(halt_out)
  );
  epa_mem_model u_mem (
    .clk_in(core_clk_in), .clear_in(clr), .mem_in(mem_out), .rdata_out(mem_rdata_in),
    .rd_cnt_out(rd_cnt), .first_out(first), .wr_cnt_out(wr_cnt), .wr_out(wr)
  );

  initial forever #5 core_clk_in = ~core_clk_in;
  initial forever #6 link_clk_in = ~link_clk_in;

  task automatic check(input string name, input logic [40:0] seen, input logic [40:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the hang limit is far above the under two thousand cycles the run needs
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // each ack toggle answers the oldest note
  always @(posedge link_clk_in)
  begin
    if (link_rst_b_in && link_ack_out !== ack_seen && q.size() > 0)
    begin
      me = q.pop_front();
      check("link answer", link_rdata_out & me[15:8], me[7:0] & me[15:8]);
    end
    ack_seen = link_ack_out;
  end

  task automatic do_reset();
    rst_b_in <= 1'b0;
    link_rst_b_in <= 1'b0;
    q.delete();
    repeat (10) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    link_rst_b_in <= 1'b1;
    repeat (5) @(posedge link_clk_in);
  endtask

  // request is held after the strobe until the ack toggles
  task automatic send(input logic w, input logic [7:0] sel, input logic [7:0] d, input logic [15:0] note);
    q.push_back(note);
    @(posedge link_clk_in);
    ack0 = link_ack_out;
    link_strobe_in <= 1'b1;
    link_req_in <= '{wr: w, sel: sel, data: d};
    @(posedge link_clk_in);
    link_strobe_in <= 1'b0;
  endtask

  task automatic wait_ack();
    while (link_ack_out === ack0)
      @(posedge link_clk_in);
  endtask

  task automatic acc(input logic w, input logic [7:0] sel, input logic [7:0] d, input logic [15:0] note);
    send(w, sel, d, note);
    wait_ack();
  endtask

  task automatic pulse_clr();
    @(posedge core_clk_in);
    clr <= 1'b1;
    @(posedge core_clk_in);
    clr <= 1'b0;
  endtask

  task automatic read_resets();
    foreach (regs[i])
      acc(1'b0, regs[i], 8'h00, 16'hFF00); // zero after reset
    acc(1'b0, 8'hB7, 8'h00, 16'hC100); // flags clear
  endtask

  initial
  begin
    logic [7:0] d;
    logic [15:0] ah;
    logic [15:0] crc;
    d = 8'($urandom(32'h94F61C94));
    do_reset();
    read_resets();
    foreach (rw[i])
    begin
      d = 8'($urandom());
      acc(1'b1, rw[i], d, 16'h0000);
      acc(1'b0, rw[i], 8'h00, {8'hFF, d}); // reads back
    end
    acc(1'b1, 8'h02, 8'h00, 16'h0000); // tool drops halt
    check("halt low", halt_out, 1'b0); // halt follows control
    ah = 16'($urandom());
    acc(1'b1, 8'hAF, ah[15:8], 16'h0000); // tool loads high byte
    acc(1'b1, 8'hAE, ah[7:0], 16'h0000); // tool loads low byte
    pulse_clr();
    // each refusal must set the error flag and leave memory alone
    foreach (cs[k])
    begin
      acc(1'b1, 8'hDF, {7'h00, cs[k][2]}, 16'h0000); // tool writes enable
      acc(1'b1, 8'h02, {7'h00, cs[k][1]}, 16'h0000); // tool sets halt control after the enable
      @(posedge core_clk_in);
      wr_lock_in <= cs[k][0];
      rd_lock_in <= cs[k][0];
      d = 8'($urandom());
      acc(1'b1, 8'hBF, d, 16'h0000);
      acc(1'b0, 8'hB7, 8'h00, {8'hC1, cs[k][0], cs[k][0], 5'h00, cs[k] != 3'h6}); // flags
    end
    check("memory write", {wr_cnt, wr}, {8'h01, ah, d}); // one write
    check("halt high", halt_out, 1'b1); // halt follows control
    d = 8'($urandom());
    pulse_clr();
    send(1'b1, 8'hA9, d, 16'h0000); // start block crc
    repeat (20) @(posedge core_clk_in);
    check("busy", link_status_out[EPA_LINK_BUSY_BIT], 1'b1); // busy in crc
    wait_ack();
    check("block reads", {rd_cnt, first}, {17'h100, d, 8'h00}); // block range
    crc = EPA_CRC16_INIT;
    for (int i = 0; i < 256; i++)
    begin
      crc = crc ^ {i[7:0] ^ d, 8'h00};
      for (int j = 0; j < 8; j++)
        crc = crc[15] ? ((crc << 1) ^ EPA_CRC16_POLY) : (crc << 1);
    end
    acc(1'b0, 8'hA9, 8'h00, {8'hFF, crc[7:0]}); // low byte
    acc(1'b0, 8'hAA, 8'h00, {8'hFF, crc[15:8]}); // high byte
    check("idle", link_status_out[EPA_LINK_BUSY_BIT], 1'b0); // busy clears
    pulse_clr();
    send(1'b1, 8'hAA, 8'($urandom()), 16'h0000); // start full crc
    // one read every three core cycles: 60 cycles give well over eight reads
    repeat (60) @(posedge core_clk_in);
    check("full start", {first, rd_cnt > 17'h8, link_status_out[7]}, {16'h0000, 2'h3});
    // the full run is far too long; abort it with a reset in mid-run
    do_reset();
    read_resets();
    end_sim();
  end
endmodule

bind epa_regs epa_regs_props u_props (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
  .link_rst_b_in(link_rst_b_in), .link_strobe_in(link_strobe_in), .link_ack_out(link_ack_out),
  .link_status_out(link_status_out), .mem_out(mem_out), .halt_out(halt_out)
);
